// ---- verif/gpg_pad_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// pad: device driver wins, then outside driver, pull-up, float
module gpg_pad_model #(
	parameter N = 8
) (
	input  wire         mclk_i,
	input  wire [N-1:0] oe_i,
	input  wire [N-1:0] out_i,
	input  wire [N-1:0] pu_i,
	input  wire [N-1:0] ext_en_i,
	input  wire [N-1:0] ext_val_i,
	output wire [N-1:0] pad_o
);
	// undriven pins change every cycle
	reg [N-1:0] float_q = {N{1'b0}};
	always @(posedge mclk_i) float_q <= ~float_q;
	assign pad_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pu_i | float_q));
endmodule // gpg_pad_model

// ---- verif/gpg_port_bench.sv ----
`timescale 1ns/1ps
`include "gpg_port_map.vh"
module gpg_port_bench;
	reg         mclk_i = 1'b0, nrst_i = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_clamp_i = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0, rdat;
	reg         rerr;
	reg  [7:0]  x_en = 8'h00, x_val = 8'h00, ext_int_en_i = 8'h00, ext_int_async_edge_i = 8'h00;
	reg  [7:0]  toggle_override_en_i = 8'h00, pullup_override_en_i, pullup_override_val_i, direction_override_en_i;
	reg  [7:0]  direction_override_val_i, pin_value_override_en_i, pin_value_override_val_i;
	reg  [7:0]  input_enable_override_en_i, input_enable_override_val_i;
	wire [31:0] prdata;
	wire        pready, pslverr;
	wire [7:0]  pad_in_i, pad_out_o, pad_oe_o, pullup_en_o, ext_int_flag_set_o, alt_fn_sampled_input_o, analog_pad_link_o;
	integer     n_errors = 0, num_checks = 0;
	gpg_port u_gpg_port (.*);
	gpg_pad_model u_gpg_pad_model (.mclk_i(mclk_i), .oe_i(pad_oe_o), .out_i(pad_out_o), .pu_i(pullup_en_o),
		.ext_en_i(x_en), .ext_val_i(x_val), .pad_o(pad_in_i));
	initial begin
		forever #5 mclk_i = ~mclk_i;
	end
	task ovr(input [63:0] v);
		{direction_override_en_i, direction_override_val_i, pin_value_override_en_i, pin_value_override_val_i,
			pullup_override_en_i, pullup_override_val_i, input_enable_override_en_i, input_enable_override_val_i} <= v;
	endtask
	task chk(input [31:0] s, input [31:0] e);
		num_checks = num_checks + 1;
		if (s !== e) begin
			n_errors = n_errors + 1;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task apb(input [11:0] a, input w, input [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		@(posedge mclk_i);
		while (pready !== 1'b1) @(posedge mclk_i);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rd(input [11:0] a, input [31:0] e);
		apb(a, 1'b0, 32'h0);
		chk(rdat, e);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#20000 n_errors = n_errors + 1;
		report_and_stop;
	end
	initial begin
		ovr(64'h0);
		repeat (2) @(posedge mclk_i);
		nrst_i <= 1'b1;
		rd(`GPG_OFF_DIR, 32'h0);
		rd(`GPG_OFF_CTRL, 32'h0);
		apb(`GPG_OFF_OUT, 1'b1, 32'h0f);
		apb(`GPG_OFF_DIR, 1'b1, 32'h33);
		x_en <= 8'hcc;
		x_val <= 8'h80;
		#1 chk(pad_oe_o, 32'h33);
		chk(pad_out_o & pad_oe_o, 32'h03);
		chk(pullup_en_o, 32'h0c);
		rd(`GPG_OFF_IN, 32'h83);
		apb(`GPG_OFF_CTRL, 1'b1, 32'h1);
		#1 chk(pullup_en_o, 32'h0);
		apb(`GPG_OFF_CTRL, 1'b1, 32'h0);
		apb(`GPG_OFF_OUT, 1'b1, 32'h0e);
		rd(`GPG_OFF_IN, 32'h82);
		apb(`GPG_OFF_IN, 1'b1, 32'h05);
		rd(`GPG_OFF_OUT, 32'h0b);
		@(posedge mclk_i);
		toggle_override_en_i <= 8'h80;
		@(posedge mclk_i);
		toggle_override_en_i <= 8'h00;
		rd(`GPG_OFF_OUT, 32'h8b);
		$display("register and pin tests done");
		@(posedge mclk_i);
		ovr(64'hfff0_ffa5_ff3c_ff0f);
		{x_en, x_val} <= 16'hff8f;
		#1 chk(pad_oe_o, 32'hf0);
		chk(pad_out_o & pad_oe_o, 32'ha0);
		chk(pullup_en_o, 32'h3c);
		chk(alt_fn_sampled_input_o, 32'h0f);
		@(posedge mclk_i);
		ovr(64'h0);
		apb(`GPG_OFF_DIR, 1'b1, 32'h0);
		ext_int_en_i <= 8'h01;
		ext_int_async_edge_i <= 8'h06;
		sleep_clamp_i <= 1'b1;
		rd(`GPG_OFF_IN, 32'h01);
		#1 chk(alt_fn_sampled_input_o, 32'h01);
		chk(analog_pad_link_o, 32'h8f);
		@(posedge mclk_i);
		ovr(64'h0000_0000_0000_ffff);
		#1 chk(alt_fn_sampled_input_o, 32'h8f);
		@(posedge mclk_i);
		ovr(64'h0);
		sleep_clamp_i <= 1'b0;
		@(posedge mclk_i);
		#1 chk(ext_int_flag_set_o, 32'h06);
		$display("override and sleep tests done");
		apb(12'h010, 1'b1, 32'hff);
		chk(rerr, 32'h1);
		rd(`GPG_OFF_DIR, 32'h0);
		rd(12'h010, 32'h0);
		chk(rerr, 32'h1);
		apb(`GPG_OFF_DIR, 1'b1, 32'h0f);
		#1 chk(pullup_en_o, 32'h80);
		chk(pad_oe_o, 32'h0f);
		@(posedge mclk_i);
		nrst_i <= 1'b0;
		#1 chk(pad_oe_o, 32'h0);
		chk(pullup_en_o, 32'h0);
		@(posedge mclk_i);
		nrst_i <= 1'b1;
		rd(`GPG_OFF_DIR, 32'h0);
		$display("error and reset tests done");
		report_and_stop;
	end
endmodule // gpg_port_bench

// ---- verif/gpg_port_sva.sv ----
`timescale 1ns/1ps
// ==========================================================
// port checker
module gpg_port_sva #(
	parameter PIN_COUNT = 8
) (
	input wire                 mclk_i,
	input wire                 nrst_i,
	input wire                 psel,
	input wire                 penable,
	input wire [11:0]          paddr,
	input wire                 pslverr,
	input wire [PIN_COUNT-1:0] pad_in_i,
	input wire [PIN_COUNT-1:0] pad_out_o,
	input wire [PIN_COUNT-1:0] pad_oe_o,
	input wire [PIN_COUNT-1:0] pullup_en_o,
	input wire                 sleep_clamp_i,
	input wire [PIN_COUNT-1:0] ext_int_flag_set_o,
	input wire [PIN_COUNT-1:0] pullup_override_en_i,
	input wire [PIN_COUNT-1:0] pullup_override_val_i,
	input wire [PIN_COUNT-1:0] direction_override_en_i,
	input wire [PIN_COUNT-1:0] direction_override_val_i,
	input wire [PIN_COUNT-1:0] pin_value_override_en_i,
	input wire [PIN_COUNT-1:0] pin_value_override_val_i,
	input wire [PIN_COUNT-1:0] analog_pad_link_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!nrst_i);
	a_oe_override: assert property ((direction_override_en_i & (pad_oe_o ^ direction_override_val_i)) == 0)
		else $error("driver enable ignores override");
	a_pu_override: assert property ((pullup_override_en_i & (pullup_en_o ^ pullup_override_val_i)) == 0)
		else $error("pull-up ignores override");
	a_pval_override: assert property ((pad_oe_o & pin_value_override_en_i & (pad_out_o ^ pin_value_override_val_i)) == 0)
		else $error("driven value ignores override");
	a_analog_link: assert property (analog_pad_link_o == pad_in_i)
		else $error("analog link differs from pad");
	a_unmapped_err: assert property (psel && penable && paddr > 12'h00c |-> pslverr)
		else $error("no error on unmapped access");
	a_wake_cause: assert property (|ext_int_flag_set_o |-> $past(sleep_clamp_i, 2) && !$past(sleep_clamp_i))
		else $error("wake flag without clamp release");
	a_wake_once: assert property (|ext_int_flag_set_o |=> ext_int_flag_set_o == 0)
		else $error("wake flag longer than one cycle");
	a_reset_quiet: assert property (disable iff (1'b0) !nrst_i |-> pad_oe_o == 0 && pullup_en_o == 0)
		else $error("driver or pull-up on in reset");
endmodule // gpg_port_sva

bind gpg_port gpg_port_sva #(.PIN_COUNT(PIN_COUNT)) u_gpg_port_sva (.*);

// ---- verilog/gpg_pin_sync.v ----
`timescale 1ns/1ps

// ==========================================================
// falling-edge flop plus rising-edge flop synchroniser, one per pin
module gpg_pin_sync #(
	parameter WIDTH = 8
) (
	input  wire             mclk_i,
	input  wire             nrst_i,
	input  wire [WIDTH-1:0] din_i,
	output wire [WIDTH-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			reg latch_q;
			reg sync_q;
			// R2 hold stage closes on falling edge
			// same value at the flop as a clock-high latch, without the edge race
			always @(negedge mclk_i or negedge nrst_i) begin
				if (!nrst_i)
					latch_q <= 1'b0;
				else
					latch_q <= din_i[g];
			end
			// R2 rising edge capture
			always @(posedge mclk_i or negedge nrst_i) begin
				if (!nrst_i)
					sync_q <= 1'b0;
				else
					sync_q <= latch_q;
			end
			assign sync_o[g] = sync_q;
		end
	endgenerate

endmodule // gpg_pin_sync

// ---- verilog/gpg_port.v ----
// Operation
// R1: input bit shows synchronised pin level in any direction.
// R2: pin passes a clock-high latch, then into input bit on rising edge; the code uses a falling-edge flop in place of the latch.
// R3: external transition reaches input bit after half to one and half periods.
// R4: software-driven value reaches input bit one period after the write.
// R5: software must idle one instruction before reading back a written pin.
// R6: sleep clamp forces digital input low before the Schmitt trigger.
// R7: external interrupt enabled pins escape the clamp; others are clamped.
// R8: high disabled async edge interrupt pin flags on wake from clamp.
// R9: pull-ups are off while reset is active.
// R10: pull-up on for dir,out,puoff = 010 unless override selects override value.
// R11: driver enable follows direction override when enabled, else direction bit.
// R12: driven value comes from value override when enabled, else output bit.
// R13: toggle override inverts the output register bit.
// R14: input enable follows its override when enabled, else sleep state.
// R15: alternate functions get input after Schmitt, before synchroniser.
// R16: analog link connects straight to the pad, bypassing digital gating.
// R17: unused override inputs are tied inactive by the owning module.
// R18: register strobes shared per port; clock, clamp, pull-up off global.
// R19: direction one drives output bit; direction zero makes an input.
// R20: writing one to input register bit toggles the output bit.
// R21: pins tri-state at once when reset asserts, without clock.
// R22: global pull-up off disables every pull-up; an enabled pull-up override still sets pullup_en_o from its value.
`timescale 1ns/1ps
`include "gpg_port_map.vh"

module gpg_port #(
	parameter PIN_COUNT = 8
) (
	input  wire                 mclk_i,
	input  wire                 nrst_i,
	// APB slave
	input  wire                 psel,
	input  wire                 penable,
	input  wire                 pwrite,
	input  wire [11:0]          paddr,
	input  wire [31:0]          pwdata,
	output reg  [31:0]          prdata,
	output wire                 pready,
	output wire                 pslverr,
	// pad side
	input  wire [PIN_COUNT-1:0] pad_in_i,
	output wire [PIN_COUNT-1:0] pad_out_o,
	output wire [PIN_COUNT-1:0] pad_oe_o,
	output wire [PIN_COUNT-1:0] pullup_en_o,
	// sleep controller and external interrupts
	input  wire                 sleep_clamp_i,
	input  wire [PIN_COUNT-1:0] ext_int_en_i,
	input  wire [PIN_COUNT-1:0] ext_int_async_edge_i,
	output wire [PIN_COUNT-1:0] ext_int_flag_set_o,
	// alternate function overrides
	input  wire [PIN_COUNT-1:0] pullup_override_en_i,
	input  wire [PIN_COUNT-1:0] pullup_override_val_i,
	input  wire [PIN_COUNT-1:0] direction_override_en_i,
	input  wire [PIN_COUNT-1:0] direction_override_val_i,
	input  wire [PIN_COUNT-1:0] pin_value_override_en_i,
	input  wire [PIN_COUNT-1:0] pin_value_override_val_i,
	input  wire [PIN_COUNT-1:0] toggle_override_en_i,
	input  wire [PIN_COUNT-1:0] input_enable_override_en_i,
	input  wire [PIN_COUNT-1:0] input_enable_override_val_i,
	output wire [PIN_COUNT-1:0] alt_fn_sampled_input_o,
	output wire [PIN_COUNT-1:0] analog_pad_link_o
);

	// ==========================================================
	// register state
	reg  [PIN_COUNT-1:0] pin_direction_bit_q;
	reg  [PIN_COUNT-1:0] pin_direction_bit_d;
	reg  [PIN_COUNT-1:0] pin_output_bit_q;
	reg  [PIN_COUNT-1:0] pin_output_bit_d;
	reg                  global_pullup_off_q;
	reg                  global_pullup_off_d;
	wire [PIN_COUNT-1:0] pin_input_bit;

	// ==========================================================
	// APB decode
	wire        apb_setup;
	wire        apb_access;
	wire        apb_wr;
	wire        hit_dir;
	wire        hit_out;
	wire        hit_in;
	wire        hit_ctrl;
	wire        hit_any;
	reg  [31:0] rd_mux;

	assign apb_setup  = psel & ~penable;
	assign apb_access = psel & penable;
	assign apb_wr     = apb_access & pwrite & hit_any;
	assign hit_dir    = (paddr == `GPG_OFF_DIR);
	assign hit_out    = (paddr == `GPG_OFF_OUT);
	assign hit_in     = (paddr == `GPG_OFF_IN);
	assign hit_ctrl   = (paddr == `GPG_OFF_CTRL);
	assign hit_any    = hit_dir | hit_out | hit_in | hit_ctrl;

	// zero wait states: answer in the first access cycle
	assign pready  = 1'b1;
	assign pslverr = apb_access & ~hit_any;

	always @(*) begin
		rd_mux = 32'h00000000;
		case (1'b1)
			hit_dir:  rd_mux[PIN_COUNT-1:0] = pin_direction_bit_q;
			hit_out:  rd_mux[PIN_COUNT-1:0] = pin_output_bit_q;
			// R1 read regardless of direction
			hit_in:   rd_mux[PIN_COUNT-1:0] = pin_input_bit;
			hit_ctrl: rd_mux[`GPG_CTRL_PUOFF_BIT] = global_pullup_off_q;
			default:  rd_mux = 32'h00000000;
		endcase
	end

	// read data captured in setup so it leaves a flop
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i)
			prdata <= 32'h00000000;
		else if (apb_setup && !pwrite)
			prdata <= rd_mux;
	end

	// ==========================================================
	// register updates
	wire [PIN_COUNT-1:0] sw_toggle;

	// R20 write one to input bit toggles
	assign sw_toggle = (apb_wr && hit_in) ? pwdata[PIN_COUNT-1:0] : {PIN_COUNT{1'b0}};

	always @(*) begin
		pin_direction_bit_d = pin_direction_bit_q;
		pin_output_bit_d    = pin_output_bit_q;
		global_pullup_off_d = global_pullup_off_q;
		// R18 one strobe per register for all pins
		if (apb_wr && hit_dir)
			pin_direction_bit_d = pwdata[PIN_COUNT-1:0];
		if (apb_wr && hit_out)
			pin_output_bit_d = pwdata[PIN_COUNT-1:0];
		if (apb_wr && hit_ctrl)
			global_pullup_off_d = pwdata[`GPG_CTRL_PUOFF_BIT];
		// R13 toggle override inverts bit
		pin_output_bit_d = pin_output_bit_d ^ (sw_toggle | toggle_override_en_i);
	end

	// R21 async reset clears direction
	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pin_direction_bit_q <= `GPG_RST_DIR;
			pin_output_bit_q    <= `GPG_RST_OUT;
			global_pullup_off_q <= `GPG_RST_PUOFF;
		end else begin
			pin_direction_bit_q <= pin_direction_bit_d;
			pin_output_bit_q    <= pin_output_bit_d;
			global_pullup_off_q <= global_pullup_off_d;
		end
	end

	// ==========================================================
	// per pin pad control
	wire [PIN_COUNT-1:0] input_enable;
	wire [PIN_COUNT-1:0] schmitt_out;

	genvar g;
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin
			wire drv_en;
			wire pu_norm;
			wire sleep_kill;

			// R17 absent overrides tied low stay inactive
			// R11 R19 driver enable selection
			assign drv_en = direction_override_en_i[g] ? direction_override_val_i[g]
				: pin_direction_bit_q[g];
			// R21 tri-state gated by reset
			assign pad_oe_o[g] = nrst_i & drv_en;
			// R12 driven value selection
			assign pad_out_o[g] = pin_value_override_en_i[g] ? pin_value_override_val_i[g]
				: pin_output_bit_q[g];

			// R10 R22 pull-up truth table
			assign pu_norm = ~pin_direction_bit_q[g] & pin_output_bit_q[g] & ~global_pullup_off_q;
			// R9 pull-up off in reset
			assign pullup_en_o[g] = nrst_i & (pullup_override_en_i[g] ? pullup_override_val_i[g]
				: pu_norm);

			// R6 R7 clamp unless interrupt enabled
			assign sleep_kill = sleep_clamp_i & ~ext_int_en_i[g];
			// R14 input enable override
			assign input_enable[g] = input_enable_override_en_i[g] ? input_enable_override_val_i[g]
				: ~sleep_kill;
			// R6 clamp to ground before Schmitt
			assign schmitt_out[g] = pad_in_i[g] & input_enable[g];
		end
	endgenerate

	// R15 unsynchronised input to alternates
	assign alt_fn_sampled_input_o = schmitt_out;
	// R16 raw pad level to analog link
	assign analog_pad_link_o = pad_in_i;

	// ==========================================================
	// input synchroniser
	// R3 R4 latch timing sets delay
	gpg_pin_sync #(
		.WIDTH (PIN_COUNT)
	) u_sync (
		.mclk_i (mclk_i),
		.nrst_i (nrst_i),
		.din_i  (schmitt_out),
		.sync_o (pin_input_bit)
	);

	// ==========================================================
	// wake edge flags
	gpg_wake_detect #(
		.WIDTH (PIN_COUNT)
	) u_wake (
		.mclk_i               (mclk_i),
		.nrst_i               (nrst_i),
		.sleep_clamp_i        (sleep_clamp_i),
		.pin_level_i          (pad_in_i),
		.ext_int_en_i         (ext_int_en_i),
		.ext_int_async_edge_i (ext_int_async_edge_i),
		.ext_int_flag_set_o   (ext_int_flag_set_o)
	);

endmodule // gpg_port

// ---- verilog/gpg_port_map.vh ----
`ifndef GPG_PORT_MAP_VH
`define GPG_PORT_MAP_VH

// ==========================================================
// register byte offsets
`define GPG_OFF_DIR 12'h000
`define GPG_OFF_OUT 12'h004
`define GPG_OFF_IN 12'h008
`define GPG_OFF_CTRL 12'h00c

// ==========================================================
// control register fields
`define GPG_CTRL_PUOFF_BIT 0

// ==========================================================
// reset values
`define GPG_RST_DIR 8'h00
`define GPG_RST_OUT 8'h00
`define GPG_RST_PUOFF 1'b0

`endif

// ---- verilog/gpg_wake_detect.v ----
`timescale 1ns/1ps

// ==========================================================
// flags edge interrupts produced by releasing the clamp
module gpg_wake_detect #(
	parameter WIDTH = 8
) (
	input  wire             mclk_i,
	input  wire             nrst_i,
	input  wire             sleep_clamp_i,
	input  wire [WIDTH-1:0] pin_level_i,
	input  wire [WIDTH-1:0] ext_int_en_i,
	input  wire [WIDTH-1:0] ext_int_async_edge_i,
	output reg  [WIDTH-1:0] ext_int_flag_set_o
);

	reg sleep_q;

	always @(posedge mclk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sleep_q            <= 1'b0;
			ext_int_flag_set_o <= {WIDTH{1'b0}};
		end else begin
			sleep_q <= sleep_clamp_i;
			// R8 clamp release seen as edge
			if (sleep_q && !sleep_clamp_i)
				ext_int_flag_set_o <= pin_level_i & ~ext_int_en_i & ext_int_async_edge_i;
			else
				ext_int_flag_set_o <= {WIDTH{1'b0}};
		end
	end

endmodule // gpg_wake_detect
